// File: rtl/dtc_timer_counter.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_counter
   import dtc_pkg::*;
#(
   parameter int MC_CLKS = CLKS_PER_MC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata_q,
   // Interrupt unit
   input wire logic ack_ovf_a,
   input wire logic ack_ovf_b,
   input wire logic ack_ext_a,
   input wire logic ack_ext_b,
   output logic [7:0] timer_irq_control_q,
   // Serial port baud source
   output logic baud_tick_q,
   // Pins
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic count_pin_a,
   input wire logic count_pin_b
);

   if (MC_CLKS < 2 || MC_CLKS > 16) begin : g_bad_mc
      $error("MC_CLKS must lie in 2..16");
   end

   function automatic logic hit(input logic [7:0] a);
      return sfr_wr && (sfr_addr == a);
   endfunction

   function automatic dtc_count_type step(
      input dtc_mode_type m,
      input logic [7:0] tl,
      input logic [7:0] th,
      input logic inc
   );
      dtc_count_type r;
      r.ovf = 1'b0;
      r.th = th;
      r.tl = tl;
      if (inc) begin
         unique case (m)
            DTC_MODE_13BIT: begin
               // Upper three low-byte bits are left as they are
               r.ovf = (th == 8'hff) && (tl[4:0] == 5'h1f);
               {r.th, r.tl[4:0]} = {th, tl[4:0]} + 13'h1;
            end
            DTC_MODE_16BIT: begin
               r.ovf = ({th, tl} == 16'hffff);
               {r.th, r.tl} = {th, tl} + 16'h1;
            end
            DTC_MODE_RELOAD: begin
               r.ovf = (tl == 8'hff);
               r.tl = r.ovf ? th : tl + 8'h1;
            end
            DTC_MODE_SPLIT: begin
               r.ovf = (tl == 8'hff);
               r.tl = tl + 8'h1;
            end
         endcase
      end
      return r;
   endfunction

   logic [3:0] mc_cnt_q;
   logic mc_tick;
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   dtc_tmode_type [1:0] mode_q;
   logic [7:0] tl_q [2];
   logic [7:0] th_q [2];
   logic [1:0] cpin;
   logic [1:0] xpin;
   logic [1:0] cpin_q;
   logic [1:0] xpin_q;
   logic [1:0] cfall;
   logic [1:0] xfall;
   logic [1:0] run;
   logic [1:0] inc;
   logic split0;
   logic hold1;
   logic th0_inc;
   logic th0_ovf;
   logic tf0_set;
   logic tf1_set;
   dtc_count_type s0;
   dtc_count_type s1;

   assign cpin = {count_pin_b, count_pin_a};
   assign xpin = {ext_irq_pin_b, ext_irq_pin_a};
   assign split0 = (mode_q[0].mode == DTC_MODE_SPLIT);
   assign hold1 = (mode_q[1].mode == DTC_MODE_SPLIT);

   // Machine cycle enable
   assign mc_tick = (mc_cnt_q == 4'(MC_CLKS - 1));
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mc_cnt_q <= 4'h0;
      end else begin
         mc_cnt_q <= mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
      end
   end

   // Pin samples, one per machine cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpin_q <= 2'b11;
         xpin_q <= 2'b11;
      end else if (mc_tick) begin
         cpin_q <= cpin;
         xpin_q <= xpin;
      end
   end

   // While timer 0 is split, its high byte owns run_bit_b
   assign run[0] = ctl_q[RUN_BIT_A];
   assign run[1] = split0 ? 1'b1 : ctl_q[RUN_BIT_B];

   for (genvar i = 0; i < 2; i++) begin : g_tmr
      assign cfall[i] = mc_tick && cpin_q[i] && !cpin[i];
      assign xfall[i] = mc_tick && xpin_q[i] && !xpin[i];
      assign inc[i] = run[i] && (!mode_q[i].gate || xpin[i])
         && (mode_q[i].cnt_sel ? cfall[i] : mc_tick)
         && !(i == 1 && hold1);
   end

   assign s0 = step(mode_q[0].mode, tl_q[0], th_q[0], inc[0]);
   assign s1 = step(mode_q[1].mode, tl_q[1], th_q[1], inc[1]);
   // Split high byte counts machine cycles only, ignoring gate and pins
   assign th0_inc = split0 && mc_tick && ctl_q[RUN_BIT_B];
   assign th0_ovf = th0_inc && (th_q[0] == 8'hff);
   assign tf0_set = s0.ovf;
   // Timer 1 keeps ticking the serial port but loses its flag when split
   assign tf1_set = split0 ? th0_ovf : s1.ovf;

   // Count registers; a software write beats a same-cycle count
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tl_q[0] <= COUNT_RESET;
         th_q[0] <= COUNT_RESET;
      end else begin
         tl_q[0] <= hit(ADDR_TL0) ? sfr_wdata : s0.tl;
         if (hit(ADDR_TH0)) begin
            th_q[0] <= sfr_wdata;
         end else if (split0) begin
            th_q[0] <= th0_inc ? th_q[0] + 8'h1 : th_q[0];
         end else begin
            th_q[0] <= s0.th;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tl_q[1] <= COUNT_RESET;
         th_q[1] <= COUNT_RESET;
      end else begin
         tl_q[1] <= hit(ADDR_TL1) ? sfr_wdata : s1.tl;
         th_q[1] <= hit(ADDR_TH1) ? sfr_wdata : s1.th;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= MODE_RESET;
      end else if (hit(ADDR_MODE)) begin
         mode_q <= sfr_wdata;
      end
   end

   // Control flags: hardware sets win over write or ack clears
   always_comb begin
      ctl_d = hit(ADDR_CTRL) ? sfr_wdata : ctl_q;
      if (!hit(ADDR_CTRL)) begin
         if (ack_ovf_a) begin
            ctl_d[OVERFLOW_FLAG_A] = 1'b0;
         end
         if (ack_ovf_b) begin
            ctl_d[OVERFLOW_FLAG_B] = 1'b0;
         end
         if (ack_ext_a && ctl_q[EXT_TRIGGER_TYPE_A]) begin
            ctl_d[EXT_IRQ_FLAG_A] = 1'b0;
         end
         if (ack_ext_b && ctl_q[EXT_TRIGGER_TYPE_B]) begin
            ctl_d[EXT_IRQ_FLAG_B] = 1'b0;
         end
      end
      ctl_d[OVERFLOW_FLAG_A] = ctl_d[OVERFLOW_FLAG_A] | tf0_set;
      ctl_d[OVERFLOW_FLAG_B] = ctl_d[OVERFLOW_FLAG_B] | tf1_set;
      // Level mode: the flag follows the sampled pin, not the ack
      if (ctl_d[EXT_TRIGGER_TYPE_A]) begin
         ctl_d[EXT_IRQ_FLAG_A] = ctl_d[EXT_IRQ_FLAG_A] | xfall[0];
      end else if (mc_tick) begin
         ctl_d[EXT_IRQ_FLAG_A] = !xpin[0];
      end
      if (ctl_d[EXT_TRIGGER_TYPE_B]) begin
         ctl_d[EXT_IRQ_FLAG_B] = ctl_d[EXT_IRQ_FLAG_B] | xfall[1];
      end else if (mc_tick) begin
         ctl_d[EXT_IRQ_FLAG_B] = !xpin[1];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= CTRL_RESET;
         timer_irq_control_q <= CTRL_RESET;
         baud_tick_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         timer_irq_control_q <= ctl_d;
         baud_tick_q <= s1.ovf;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_q <= 8'h00;
      end else if (!sfr_rd) begin
         sfr_rdata_q <= 8'h00;
      end else begin
         unique case (sfr_addr)
            ADDR_CTRL: sfr_rdata_q <= ctl_q;
            ADDR_MODE: sfr_rdata_q <= mode_q;
            ADDR_TL0: sfr_rdata_q <= tl_q[0];
            ADDR_TL1: sfr_rdata_q <= tl_q[1];
            ADDR_TH0: sfr_rdata_q <= th_q[0];
            ADDR_TH1: sfr_rdata_q <= th_q[1];
            default: sfr_rdata_q <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   a_tf1_set: assert property (tf1_set |=> ctl_q[OVERFLOW_FLAG_B])
      else $error("overflow flag b not set");
   a_tf0_ack: assert property (ack_ovf_a && !tf0_set && !hit(ADDR_CTRL)
      |=> !ctl_q[OVERFLOW_FLAG_A])
      else $error("overflow flag a not cleared by ack");
   a_run_off_hold: assert property (!ctl_q[RUN_BIT_A] && !hit(ADDR_TL0)
      |=> $stable(tl_q[0]))
      else $error("timer 0 low byte moved while stopped");
   a_edge_flag_b: assert property (ctl_q[EXT_TRIGGER_TYPE_B] && !hit(ADDR_CTRL)
      && xfall[1] |=> ctl_q[EXT_IRQ_FLAG_B])
      else $error("edge on pin b missed");
   a_level_flag_a: assert property (!ctl_q[EXT_TRIGGER_TYPE_A] && mc_tick
      && !hit(ADDR_CTRL) |=> ctl_q[EXT_IRQ_FLAG_A] == !$past(xpin[0]))
      else $error("level flag a does not follow pin");
   a_level_no_ack: assert property (!ctl_q[EXT_TRIGGER_TYPE_B] && !mc_tick
      && !hit(ADDR_CTRL) |=> $stable(ctl_q[EXT_IRQ_FLAG_B]))
      else $error("level flag b changed between samples");
   a_mode0_wrap: assert property (inc[0] && mode_q[0].mode == DTC_MODE_13BIT
      && th_q[0] == 8'hff && tl_q[0][4:0] == 5'h1f && !sfr_wr
      |=> th_q[0] == 8'h00 && tl_q[0][4:0] == 5'h00
      && ctl_q[OVERFLOW_FLAG_A])
      else $error("mode 0 rollover wrong");
   a_gate_block: assert property (mode_q[0].gate && !xpin[0] && !split0
      && !sfr_wr |=> $stable(tl_q[0]) && $stable(th_q[0]))
      else $error("gated timer 0 counted");
   a_run_set_keep: assert property (hit(ADDR_CTRL) && sfr_wdata[RUN_BIT_A]
      && !ctl_q[RUN_BIT_A] |=> $stable(tl_q[0]))
      else $error("setting run changed the count");
   a_mode2_reload: assert property (inc[0] && mode_q[0].mode == DTC_MODE_RELOAD
      && tl_q[0] == 8'hff && !sfr_wr
      |=> tl_q[0] == $past(th_q[0]) && $stable(th_q[0]))
      else $error("mode 2 reload wrong");
   a_t1_mode3_hold: assert property (hold1 && !sfr_wr
      |=> $stable(tl_q[1]) && $stable(th_q[1]))
      else $error("timer 1 moved in mode 3");
   a_split_high: assert property (split0 && mc_tick && ctl_q[RUN_BIT_B]
      && th_q[0] == 8'hff && !sfr_wr
      |=> th_q[0] == 8'h00 && ctl_q[OVERFLOW_FLAG_B])
      else $error("split high byte overflow wrong");
   a_mc_period: assert property (mc_tick |-> ##12 mc_tick)
      else $error("machine cycle not 12 clocks");

endmodule // dtc_timer_counter
`default_nettype wire

// File: inc/dtc_pkg.sv
`default_nettype none
package dtc_pkg;
   // Register addresses on the special-function-register bus
   localparam logic [7:0] ADDR_CTRL = 8'h88;
   localparam logic [7:0] ADDR_MODE = 8'h89;
   localparam logic [7:0] ADDR_TL0 = 8'h8a;
   localparam logic [7:0] ADDR_TL1 = 8'h8b;
   localparam logic [7:0] ADDR_TH0 = 8'h8c;
   localparam logic [7:0] ADDR_TH1 = 8'h8d;
   // Bit positions in timer_irq_control
   localparam int OVERFLOW_FLAG_B = 7;
   localparam int RUN_BIT_B = 6;
   localparam int OVERFLOW_FLAG_A = 5;
   localparam int RUN_BIT_A = 4;
   localparam int EXT_IRQ_FLAG_B = 3;
   localparam int EXT_TRIGGER_TYPE_B = 2;
   localparam int EXT_IRQ_FLAG_A = 1;
   localparam int EXT_TRIGGER_TYPE_A = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   // Core clocks per machine cycle
   localparam int CLKS_PER_MC = 12;
   // Mode select values {mode_select_high, mode_select_low}
   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_type;
   // One nibble of timer_mode_register, timer 1 in bits 7..4
   typedef struct packed {
      logic gate;
      logic cnt_sel;
      dtc_mode_type mode;
   } dtc_tmode_type;
   // Result of one counting step
   typedef struct packed {
      logic ovf;
      logic [7:0] th;
      logic [7:0] tl;
   } dtc_count_type;
endpackage
`default_nettype wire

// File: sim/dtc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model #(
   parameter int HOLD = 12
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Wanted levels {count b, count a, irq b, irq a}
   input wire logic [3:0] want,
   // Pins, pulled high while idle
   output logic [3:0] pins_q
);
   int age[4];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pins_q <= 4'hf;
         age <= '{default: 0};
      end else begin
         for (int i = 0; i < 4; i++) begin
            // A level shorter than a machine cycle could be missed
            if (want[i] != pins_q[i] && age[i] >= HOLD) begin
               pins_q[i] <= want[i];
               age[i] <= 0;
            end else begin
               age[i] <= age[i] + 1;
            end
         end
      end
   end
endmodule // dtc_pin_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dtc_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr_s = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic rd_s = 1'b0;
   logic [7:0] rdata;
   logic [3:0] ack = 4'h0;
   logic [7:0] ctrl;
   logic baud;
   logic [3:0] want = 4'hf;
   logic [3:0] pins;
   logic [7:0] v;
   logic [7:0] x;
   int miscompares = 0;
   int comparisons = 0;
   int seed = 99373;
   int bauds = 0;
   int n;
   int k;
   always #12.5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (baud === 1'b1) bauds++;
   dtc_pin_model pin_u (.sys_clk(sys_clk), .nrst(nrst), .want(want), .pins_q(pins));
   dtc_timer_counter dut_u (.sys_clk(sys_clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr_s),
      .sfr_wdata(wdata), .sfr_rd(rd_s), .sfr_rdata_q(rdata), .ack_ovf_a(ack[0]), .ack_ovf_b(ack[1]),
      .ack_ext_a(ack[2]), .ack_ext_b(ack[3]), .timer_irq_control_q(ctrl), .baud_tick_q(baud),
      .ext_irq_pin_a(pins[0]), .ext_irq_pin_b(pins[1]), .count_pin_a(pins[2]), .count_pin_b(pins[3]));
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One tick of the reference counter
   function automatic dtc_count_type step(int m, int th, int tl);
      int s;
      s = m == 0 ? th * 32 + tl % 32 + 1 : m == 1 ? th * 256 + tl + 1 : tl + 1;
      step.ovf = s == (m == 0 ? 8192 : m == 1 ? 65536 : 256);
      step.th = 8'(m == 0 ? s / 32 : m == 1 ? s / 256 : th);
      step.tl = 8'(m == 2 && s == 256 ? th : m == 0 ? s % 32 : s);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic pulse(input int i);
      @(posedge sys_clk);
      ack[i] <= 1'b1;
      @(posedge sys_clk);
      ack[i] <= 1'b0;
      #1;
   endtask
   task automatic mcs(input int c);
      repeat (c * CLKS_PER_MC) @(posedge sys_clk);
   endtask
   task automatic wait_bit(input int b, input int lim, output int c);
      c = 0;
      while (ctrl[b] !== 1'b1 && c < lim) begin
         @(posedge sys_clk);
         #1 c++;
      end
   endtask
   task automatic run_case(input logic [7:0] md, ta, ha, run, input int m, b, th, tl);
      dtc_count_type c;
      logic [7:0] r;
      int t;
      int w;
      c = '{1'b0, 8'(th), 8'(tl)};
      t = 0;
      while (!c.ovf) begin
         c = step(m, c.th, c.tl);
         t++;
      end
      wr(ADDR_MODE, md);
      wr(ha, 8'(th));
      wr(ta, 8'(tl));
      wr(ADDR_CTRL, run);
      wait_bit(b, t * CLKS_PER_MC + 24, w);
      chk(8'(w >= (t - 1) * CLKS_PER_MC && ctrl[b] === 1'b1), 8'h01, "ovf time");
      rd(ta, r);
      chk(r & (m == 0 ? 8'h1f : 8'hff), c.tl, "low");
      rd(ha, r);
      chk(r, c.th, "high");
      pulse(b == 5 ? 0 : 1);
      chk(8'(ctrl[b]), 8'h00, "ack");
      wr(ADDR_CTRL, 8'h00);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Whole run needs fewer than two thousand cycles
   initial begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      $display("ERROR %0t watchdog", $time);
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         rd(8'(ADDR_CTRL + a), v);
         chk(v, 8'h00, "reset");
      end
      rd(8'h8e, v);
      chk(v, 8'h00, "unmapped");
      x = 8'(rnd());
      wr(ADDR_MODE, x);
      rd(ADDR_MODE, v);
      chk(v, x, "mode");
      // Mode 0 runs on timer 0 so that its rollover assertion is exercised
      run_case(8'h10, ADDR_TL1, ADDR_TH1, 8'h40, 1, 7, 255, 8'(rnd()) | 8'hc0);
      run_case(8'h00, ADDR_TL0, ADDR_TH0, 8'h10, 0, 5, 255, 253);
      run_case(8'h02, ADDR_TL0, ADDR_TH0, 8'h10, 2, 5, 8'(rnd()), 254);
      run_case(8'h33, ADDR_TH0, ADDR_TL0, 8'h40, 3, 7, 90, 253);
      for (int i = 0; i < 2; i++) begin
         for (int e = 0; e < 2; e++) begin
            wr(ADDR_CTRL, 8'(e << (2 * i)));
            want[i] <= 1'b0;
            wait_bit(1 + 2 * i, 3 * CLKS_PER_MC, n);
            chk(8'(ctrl[1 + 2 * i]), 8'h01, "ext set");
            pulse(2 + i);
            chk(8'(ctrl[1 + 2 * i]), 8'(1 - e), "ext ack");
            want[i] <= 1'b1;
            mcs(3);
            chk(ctrl, 8'(e << (2 * i)), "ext release");
            wr(ADDR_CTRL, 8'h00);
         end
      end
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_TL0, 8'h00);
      want[0] <= 1'b0;
      wr(ADDR_CTRL, 8'h10);
      mcs(4);
      rd(ADDR_TL0, v);
      chk(v, 8'h00, "gated");
      want[0] <= 1'b1;
      mcs(4);
      rd(ADDR_TL0, v);
      chk(8'(v >= 8'd3 && v <= 8'd5), 8'h01, "ungated");
      wr(ADDR_MODE, 8'h05);
      wr(ADDR_TL0, 8'h00);
      repeat (3) begin
         want[2] <= 1'b0;
         mcs(2);
         want[2] <= 1'b1;
         mcs(2);
      end
      rd(ADDR_TL0, v);
      chk(v, 8'h03, "counted");
      wr(ADDR_MODE, 8'h30);
      wr(ADDR_TL1, 8'h77);
      wr(ADDR_CTRL, 8'h40);
      mcs(3);
      rd(ADDR_TL1, v);
      chk(v, 8'h77, "t1 held");
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_TH1, 8'h00);
      wr(ADDR_MODE, 8'h23);
      wr(ADDR_TL1, 8'hfe);
      k = bauds;
      mcs(3);
      chk(8'(bauds - k), 8'h01, "baud");
      chk(8'(ctrl[7]), 8'h00, "no ovf b");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
